// *** rtl/dtp_config_top.sv ***
// dtp_config_top: dram row type, pci target wait limit and arbiter
// time slice configuration with the logic those settings steer.
// assumes core_clk is the pci clock and the dram/target logic share it;
// request pins arrive asynchronous and are synchronised here.
//
// Functional notes
// - row-4 field bits 4,0: 00 page mode, 01 edo, 10 sdram, 11 off.
// - row-4 register differing from 11h marks row 4 present, muxes shared pins.
// - each dram cycle takes its timing from the target row's type.
// - low register pairs 7,3 / 6,2 / 5,1 / 4,0 give rows 3..0.
// - low pairs: 00 page mode, 01 edo, 10 sdram, 11 reserved.
// - burst data phase never waits more clocks for trdy than the limit.
// - wait codes 000..011 mean 2,4,6,8 clocks; reset 8; 1xx reserved.
// - a granted agent keeps the bus for the slice from first grant.
// - after the slice, grant moves once another agent requests.
// - slice value zero turns the guaranteed slice off.
// - slice count in bits 7:2, bits 1:0 read zero, four-clock steps.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module dtp_config_top #(
    parameter int AGENTS = 4
) (
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic [9:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                dram_cycle_start,
    input  wire logic [2:0]          dram_cycle_row,
    output dtp_pkg::dtp_dram_t       dram_cycle_type,
    output logic                     dram_cycle_go,
    output logic                     dram_cycle_reject,
    output logic                     row4_populated,
    output logic                     shared_strobe_pin_sel,
    output logic                     shared_select_pin_sel,
    input  wire logic                tgt_burst_phase,
    input  wire logic                tgt_data_ready,
    output logic                     tgt_trdy,
    output logic                     tgt_wait_expired,
    input  wire logic [AGENTS-1:0]   pci_req_n,
    output logic      [AGENTS-1:0]   pci_gnt_n
);
    import dtp_pkg::*;

    localparam int IW = $clog2(AGENTS);

    // the owner index and round-robin search assume 2..8 agents
    if (AGENTS < 2 || AGENTS > 8) begin : g_bad_agents
        $error("dtp_config_top: AGENTS must be 2 to 8");
    end

    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  row4_reg;
    logic [7:0]  rows_low_reg;
    logic [2:0]  wait_code_reg;
    logic [5:0]  slice_reg;
    logic [7:0]  idx;
    logic        req_any;
    logic        wr_take;
    logic        wr_lane0;
    logic [7:0]  wbyte;
    logic [31:0] rd_value;

    assign idx      = avs_address[9:2];
    assign req_any  = avs_read | avs_write;
    assign wr_take  = avs_write & ~wait_reg;
    assign wr_lane0 = wr_take & avs_byteenable[0];
    assign wbyte    = avs_writedata[7:0];

    // one wait state: waitrequest drops for one cycle after a request
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~(req_any & wait_reg);
        end
    end

    // read view; unmapped indices and reserved bits answer zero
    always_comb begin
        rd_value = 32'h0;
        unique case (idx)
            DTP_IDX_ROW4: begin
                rd_value[DTP_ROW4_HI_BIT] = row4_reg[1];
                rd_value[DTP_ROW4_LO_BIT] = row4_reg[0];
            end
            DTP_IDX_ROWS_LOW: rd_value[7:0] = rows_low_reg;
            DTP_IDX_WAIT:     rd_value[DTP_WAIT_MSB:0] = wait_code_reg;
            DTP_IDX_SLICE:    rd_value[7:DTP_SLICE_LSB] = slice_reg;
            default:          rd_value = 32'h0;
        endcase
    end

    // read data loaded with the drop of waitrequest, held until the next
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata_reg <= 32'h0;
        end else if (avs_read && wait_reg) begin
            rdata_reg <= rd_value;
        end
    end

    // only the documented bits are stored, so reserved writes vanish
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            row4_reg      <= {DTP_ROW4_RST[DTP_ROW4_HI_BIT], DTP_ROW4_RST[DTP_ROW4_LO_BIT]};
            rows_low_reg  <= DTP_ROWS_LOW_RST;
            wait_code_reg <= DTP_WAIT_RST[DTP_WAIT_MSB:0];
            slice_reg     <= DTP_SLICE_RST[7:DTP_SLICE_LSB];
        end else if (wr_lane0) begin
            unique case (idx)
                DTP_IDX_ROW4:     row4_reg <= {wbyte[DTP_ROW4_HI_BIT], wbyte[DTP_ROW4_LO_BIT]};
                DTP_IDX_ROWS_LOW: rows_low_reg <= wbyte;
                DTP_IDX_WAIT:     wait_code_reg <= wbyte[DTP_WAIT_MSB:0];
                DTP_IDX_SLICE:    slice_reg <= wbyte[7:DTP_SLICE_LSB];
                default:          row4_reg <= row4_reg;
            endcase
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdata_reg;
    logic populated_reg;
    logic strobe_sel_reg;
    logic select_sel_reg;

    // strobe for page mode/edo, chip select for sdram, none when off
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            populated_reg  <= 1'b0;
            strobe_sel_reg <= 1'b0;
            select_sel_reg <= 1'b0;
        end else begin
            populated_reg  <= (row4_reg != 2'h3);
            strobe_sel_reg <= (row4_reg == 2'h0) || (row4_reg == 2'h1);
            select_sel_reg <= (row4_reg == 2'h2);
        end
    end

    assign row4_populated        = populated_reg;
    assign shared_strobe_pin_sel = strobe_sel_reg;
    assign shared_select_pin_sel = select_sel_reg;
    dtp_dram_t sel_type;
    logic      sel_ok;
    dtp_dram_t cyc_type_reg;
    logic      cyc_go_reg;
    logic      cyc_rej_reg;

    dtp_row_type_sel u_row_sel (
        .rows_low  (rows_low_reg),
        .row4_type (row4_reg),
        .row       (dram_cycle_row),
        .row_type  (sel_type),
        .row_ok    (sel_ok)
    );

    // type latched at cycle start; reserved or absent rows are refused
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cyc_type_reg <= DTP_STANDARD_PAGE_MODE;
            cyc_go_reg   <= 1'b0;
            cyc_rej_reg  <= 1'b0;
        end else begin
            cyc_go_reg  <= dram_cycle_start & sel_ok;
            cyc_rej_reg <= dram_cycle_start & ~sel_ok;
            if (dram_cycle_start) begin
                cyc_type_reg <= sel_type;
            end
        end
    end

    assign dram_cycle_type   = cyc_type_reg;
    assign dram_cycle_go     = cyc_go_reg;
    assign dram_cycle_reject = cyc_rej_reg;
    logic [3:0] wait_lim;
    logic [3:0] wait_cnt_reg;
    logic       trdy_reg;
    logic       expired_reg;
    logic       trdy_next;
    logic       force_trdy;

    assign wait_lim   = dtp_wait_clocks(wait_code_reg);
    // forced at the limit even without data: the limit never stretches
    assign force_trdy = (wait_cnt_reg + 4'h1) >= wait_lim;
    assign trdy_next  = tgt_burst_phase & (tgt_data_ready | force_trdy);

    // wait count restarts at every data phase
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wait_cnt_reg <= 4'h0;
            trdy_reg     <= 1'b0;
            expired_reg  <= 1'b0;
        end else begin
            trdy_reg    <= trdy_next;
            expired_reg <= tgt_burst_phase & ~tgt_data_ready & force_trdy;
            if (tgt_burst_phase && !trdy_next) begin
                wait_cnt_reg <= wait_cnt_reg + 4'h1;
            end else begin
                wait_cnt_reg <= 4'h0;
            end
        end
    end

    assign tgt_trdy         = trdy_reg;
    assign tgt_wait_expired = expired_reg;
    logic [AGENTS-1:0] req_level_n;
    logic [AGENTS-1:0] req;
    logic [AGENTS-1:0] others;
    logic [IW-1:0]     owner_reg;
    logic              owned_reg;
    logic [7:0]        slice_cnt_reg;
    logic [AGENTS-1:0] gnt_n_reg;
    logic              slice_on;
    logic              move;
    logic [IW-1:0]     pick;

    dtp_pin_sync #(
        .WIDTH (AGENTS),
        .IDLE  ({AGENTS{1'b1}})
    ) u_req_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .pin      (pci_req_n),
        .level    (req_level_n)
    );

    // first requester after cur, cur itself last
    function automatic logic [IW-1:0] rr_next(
        input logic [AGENTS-1:0] r,
        input logic [IW-1:0]     cur
    );
        int k;
        rr_next = cur;
        for (int i = AGENTS; i >= 1; i--) begin
            k = (int'(cur) + i) % AGENTS;
            if (r[k]) begin
                rr_next = IW'(k);
            end
        end
    endfunction : rr_next

    assign req      = ~req_level_n;
    assign others   = req & ~(AGENTS'(1) << owner_reg);
    assign slice_on = (slice_reg != 6'h0);
    // inside the slice the owner is held even if it idles
    always_comb begin
        move = 1'b0;
        pick = rr_next(req, owner_reg);
        if (!owned_reg) begin
            move = |req;
        end else if (|others) begin
            pick = rr_next(others, owner_reg);
            if (slice_on) begin
                move = (slice_cnt_reg == 8'h0);
            end else begin
                move = ~req[owner_reg];
            end
        end
    end

    // slice counted from the edge that first drives the new grant
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            owner_reg     <= '0;
            owned_reg     <= 1'b0;
            slice_cnt_reg <= 8'h0;
            gnt_n_reg     <= '1;
        end else if (move) begin
            owner_reg     <= pick;
            owned_reg     <= 1'b1;
            slice_cnt_reg <= {slice_reg, 2'h0};
            gnt_n_reg     <= ~(AGENTS'(1) << pick);
        end else if (slice_cnt_reg != 8'h0) begin
            slice_cnt_reg <= slice_cnt_reg - 8'h1;
        end
    end

    assign pci_gnt_n = gnt_n_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_row4_off;
        (wr_lane0 && idx == DTP_IDX_ROW4 && wbyte == DTP_ROW4_RST) |=> ##1
            (!row4_populated && !shared_strobe_pin_sel && !shared_select_pin_sel);
    endproperty
    a_row4_off: assert property (p_row4_off)
        else $error("row 4 still present after writing reset value");

    property p_row4_sdram;
        (wr_lane0 && idx == DTP_IDX_ROW4 && wbyte == 8'h10) |=> ##1
            (row4_populated && shared_select_pin_sel && !shared_strobe_pin_sel);
    endproperty
    a_row4_sdram: assert property (p_row4_sdram)
        else $error("sdram row 4 did not select chip-select function");

    property p_cycle_type;
        (dram_cycle_start && dram_cycle_row == 3'h2) |=>
            (dram_cycle_type == dtp_dram_t'({$past(rows_low_reg[6]), $past(rows_low_reg[2])}));
    endproperty
    a_cycle_type: assert property (p_cycle_type)
        else $error("row 2 cycle type does not match bits 6,2");

    property p_cycle_answer;
        dram_cycle_start |=> (dram_cycle_go ^ dram_cycle_reject);
    endproperty
    a_cycle_answer: assert property (p_cycle_answer)
        else $error("dram cycle start not answered exactly once");

    property p_reserved_pair;
        (dram_cycle_start && dram_cycle_row == 3'h1 && rows_low_reg[5] && rows_low_reg[1])
            |=> dram_cycle_reject;
    endproperty
    a_reserved_pair: assert property (p_reserved_pair)
        else $error("reserved row type was not refused");

    property p_wait_bound;
        tgt_burst_phase |-> (wait_cnt_reg < wait_lim);
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("target wait count reached the limit");

    property p_wait_two;
        (wait_code_reg == 3'h0 && tgt_burst_phase && !tgt_data_ready && wait_cnt_reg == 4'h1)
            |=> (tgt_trdy && tgt_wait_expired);
    endproperty
    a_wait_two: assert property (p_wait_two)
        else $error("code 000 did not force trdy after 2 clocks");

    property p_slice_hold;
        (owned_reg && slice_on && slice_cnt_reg != 8'h0) |=> $stable(pci_gnt_n);
    endproperty
    a_slice_hold: assert property (p_slice_hold)
        else $error("grant moved inside the guaranteed slice");

    property p_slice_move;
        (owned_reg && slice_on && slice_cnt_reg == 8'h0 && |others) |=>
            (pci_gnt_n != $past(pci_gnt_n));
    endproperty
    a_slice_move: assert property (p_slice_move)
        else $error("grant did not move after the slice");

    property p_slice_zero;
        (move && !slice_on) |=> (slice_cnt_reg == 8'h0);
    endproperty
    a_slice_zero: assert property (p_slice_zero)
        else $error("slice counter loaded while disabled");

    property p_slice_lsbs;
        (avs_read && wait_reg && idx == DTP_IDX_SLICE) |=> (avs_readdata[1:0] == 2'h0);
    endproperty
    a_slice_lsbs: assert property (p_slice_lsbs)
        else $error("slice register low bits not zero");

    property p_row4_rsvd;
        (avs_read && wait_reg && idx == DTP_IDX_ROW4) |=>
            (avs_readdata[7:5] == 3'h0 && avs_readdata[3:1] == 3'h0);
    endproperty
    a_row4_rsvd: assert property (p_row4_rsvd)
        else $error("row 4 reserved bits not zero");

    c_write: cover property (wr_lane0 && idx == DTP_IDX_SLICE);
    c_forced: cover property (tgt_wait_expired);
    c_move: cover property (owned_reg && slice_on && move);
endmodule : dtp_config_top

// *** rtl/dtp_pkg.sv ***
// dtp_pkg: register map, reset values, field layout and type codes
// for the dram type / pci timer configuration bank.
// assumes one 32-bit avalon-mm slave, byte address = 4 * register index.
package dtp_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] DTP_IDX_ROW4      = 8'h67;
    localparam logic [7:0] DTP_IDX_ROWS_LOW  = 8'h68;
    localparam logic [7:0] DTP_IDX_WAIT      = 8'h69;
    localparam logic [7:0] DTP_IDX_SLICE     = 8'h70;

    // values after reset
    localparam logic [7:0] DTP_ROW4_RST      = 8'h11;
    localparam logic [7:0] DTP_ROWS_LOW_RST  = 8'h00;
    localparam logic [7:0] DTP_WAIT_RST      = 8'h03;
    localparam logic [7:0] DTP_SLICE_RST     = 8'h20;

    // field positions
    localparam int DTP_ROW4_HI_BIT  = 4;
    localparam int DTP_ROW4_LO_BIT  = 0;
    localparam int DTP_PAIR_HI_OFS  = 4;
    localparam int DTP_WAIT_MSB     = 2;
    localparam int DTP_SLICE_LSB    = 2;
    localparam int DTP_ROW4_NUM     = 4;

    // target wait limits in pci clocks per code
    localparam logic [3:0] DTP_WAIT_CLK_0 = 4'h2;
    localparam logic [3:0] DTP_WAIT_CLK_1 = 4'h4;
    localparam logic [3:0] DTP_WAIT_CLK_2 = 4'h6;
    localparam logic [3:0] DTP_WAIT_CLK_3 = 4'h8;

    // dram technology, codes follow the two-bit type field
    typedef enum logic [1:0] {
        DTP_STANDARD_PAGE_MODE,
        DTP_EDO,
        DTP_SDRAM,
        DTP_NONE
    } dtp_dram_t;

    // wait limit of a code; reserved codes fall back to the longest
    function automatic logic [3:0] dtp_wait_clocks(input logic [2:0] code);
        unique case (code)
            3'h0:    dtp_wait_clocks = DTP_WAIT_CLK_0;
            3'h1:    dtp_wait_clocks = DTP_WAIT_CLK_1;
            3'h2:    dtp_wait_clocks = DTP_WAIT_CLK_2;
            default: dtp_wait_clocks = DTP_WAIT_CLK_3;
        endcase
    endfunction : dtp_wait_clocks

endpackage : dtp_pkg

// *** rtl/dtp_pin_sync.sv ***
// dtp_pin_sync: three-stage synchroniser for pin inputs.
// a bit changes only when the second and third stages agree.
`timescale 1ns/1ps
module dtp_pin_sync #(
    parameter int              WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_reg;

    // a zero-wide bus has nothing to synchronise
    if (WIDTH < 1) begin : g_bad_width
        $error("dtp_pin_sync: WIDTH must be at least 1");
    end

    // s1 feeds only s2, agreement is judged on s2/s3
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            s1_reg    <= IDLE;
            s2_reg    <= IDLE;
            s3_reg    <= IDLE;
            level_reg <= IDLE;
        end else begin
            s1_reg    <= pin;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= (s2_reg & s3_reg) | (level_reg & (s2_reg ^ s3_reg));
        end
    end

    assign level = level_reg;
endmodule : dtp_pin_sync

// *** rtl/dtp_row_type_sel.sv ***
// dtp_row_type_sel: picks the programmed dram type of one row.
// purely combinational; the caller registers the result.
`timescale 1ns/1ps
module dtp_row_type_sel (
    input  wire logic [7:0]        rows_low,
    input  wire logic [1:0]        row4_type,
    input  wire logic [2:0]        row,
    output dtp_pkg::dtp_dram_t     row_type,
    output logic                   row_ok
);
    import dtp_pkg::*;

    logic [1:0] pair;

    // pair of row n is bits n+4 and n; row 4 has its own field
    always_comb begin
        pair = 2'h3;
        if (row < 3'(DTP_ROW4_NUM)) begin
            pair = {rows_low[{1'b0, row[1:0]} + 3'(DTP_PAIR_HI_OFS)], rows_low[row[1:0]]};
        end else if (row == 3'(DTP_ROW4_NUM)) begin
            pair = row4_type;
        end
        row_type = dtp_dram_t'(pair);
        // code 3 is reserved for rows 0-3 and means disabled for row 4
        row_ok   = (row <= 3'(DTP_ROW4_NUM)) && (pair != 2'h3);
    end
endmodule : dtp_row_type_sel

// *** testbench/dtp_pci_agents.sv ***
// dtp_pci_agents: behavioural pci masters on the arbiter request pins.
// assumes active-low grants; the bench says which agent wants the bus.
`timescale 1ns/1ps
module dtp_pci_agents #(
    parameter int AGENTS = 2
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic [AGENTS-1:0] want,
    input  wire logic [AGENTS-1:0] pci_gnt_n,
    output logic      [AGENTS-1:0] pci_req_n,
    output int                     last_hold [AGENTS]
);
    int run [AGENTS];

    // pins are pulled up, so an idle agent shows ones
    always_ff @(posedge core_clk) begin
        pci_req_n <= reset_n ? ~want : '1;
    end

    // grant length per agent, kept when the grant leaves
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < AGENTS; i++) begin
            if (!pci_gnt_n[i]) begin
                run[i] <= run[i] + 1;
            end else begin
                if (run[i] != 0) begin
                    last_hold[i] <= run[i];
                end
                run[i] <= 0;
            end
        end
    end
endmodule : dtp_pci_agents

// *** testbench/dtp_config_top_tb.sv ***
// dtp_config_top_tb: register, dram select, target wait and arbiter tests.
// assumes one 50 MHz clock and two pci agents from dtp_pci_agents.
`timescale 1ns/1ps
module dtp_config_top_tb;
    import dtp_pkg::*;
    localparam logic [9:0] A_ROW4 = {DTP_IDX_ROW4, 2'b00};
    localparam logic [9:0] A_LOW  = {DTP_IDX_ROWS_LOW, 2'b00};
    localparam logic [9:0] A_WAIT = {DTP_IDX_WAIT, 2'b00};
    localparam logic [9:0] A_SLC  = {DTP_IDX_SLICE, 2'b00};
    logic             core_clk = 1'b0;
    logic             reset_n = 1'b0;
    logic [9:0]       avs_address = '0;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = '0;
    logic [3:0]       avs_byteenable = 4'h1;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic             dram_cycle_start = 1'b0;
    logic [2:0]       dram_cycle_row = '0;
    dtp_dram_t        dram_cycle_type;
    logic             dram_cycle_go, dram_cycle_reject;
    logic             row4_populated, shared_strobe_pin_sel, shared_select_pin_sel;
    logic             tgt_burst_phase = 1'b0;
    logic             tgt_data_ready = 1'b0;
    logic             tgt_trdy, tgt_wait_expired;
    logic [1:0]       want = '0;
    logic [1:0]       pci_req_n, pci_gnt_n;
    int               last_hold [2];
    int               mismatches = 0;
    int               checked = 0;
    int               cycles = 0;
    logic [31:0]      q;
    logic [7:0]       v;
    logic [9:0]       addr [4] = '{A_ROW4, A_LOW, A_WAIT, A_SLC};
    logic [7:0]       rst [4] = '{DTP_ROW4_RST, DTP_ROWS_LOW_RST, DTP_WAIT_RST, DTP_SLICE_RST};
    logic [7:0]       msk [4] = '{8'h11, 8'hff, 8'h07, 8'hfc};

    dtp_config_top #(.AGENTS(2)) i_dtp_config_top (.core_clk(core_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dram_cycle_start(dram_cycle_start), .dram_cycle_row(dram_cycle_row),
        .dram_cycle_type(dram_cycle_type), .dram_cycle_go(dram_cycle_go),
        .dram_cycle_reject(dram_cycle_reject), .row4_populated(row4_populated),
        .shared_strobe_pin_sel(shared_strobe_pin_sel),
        .shared_select_pin_sel(shared_select_pin_sel), .tgt_burst_phase(tgt_burst_phase),
        .tgt_data_ready(tgt_data_ready), .tgt_trdy(tgt_trdy),
        .tgt_wait_expired(tgt_wait_expired), .pci_req_n(pci_req_n), .pci_gnt_n(pci_gnt_n));

    dtp_pci_agents #(.AGENTS(2)) i_dtp_pci_agents (.core_clk(core_clk), .reset_n(reset_n),
        .want(want), .pci_gnt_n(pci_gnt_n), .pci_req_n(pci_req_n), .last_hold(last_hold));

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    // hang guard, the tests need about three hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // one avalon access; entered just after a rising edge
    task automatic bus(input logic wr_en, input logic [9:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] rdata);
        avs_address <= a;
        avs_write <= wr_en;
        avs_read <= !wr_en;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1, q);
    endtask : wr

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'h1, q);
        chk_val(q, {24'h0, exp});
    endtask : rd_chk

    // type is only meaningful when the cycle is accepted
    task automatic dram_chk(input logic [2:0] row, input logic [1:0] t, input logic go);
        dram_cycle_start <= 1'b1;
        dram_cycle_row <= row;
        @(posedge core_clk);
        dram_cycle_start <= 1'b0;
        @(posedge core_clk);
        chk_val({28'h0, go ? 2'(dram_cycle_type) : t, dram_cycle_go, dram_cycle_reject},
                {28'h0, t, go, !go});
    endtask : dram_chk

    // clocks of burst phase until trdy, and whether the limit forced it
    task automatic trdy_chk(input logic data, input int lim);
        int n;
        n = 0;
        tgt_data_ready <= data;
        tgt_burst_phase <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (tgt_trdy !== 1'b1 && n < 20);
        chk_val({tgt_wait_expired, 31'(n - 1)}, {!data, 31'(lim)});
        tgt_burst_phase <= 1'b0;
        tgt_data_ready <= 1'b0;
        @(posedge core_clk);
    endtask : trdy_chk

    task automatic wait_gnt(input logic [1:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pci_gnt_n !== exp && n < 40);
        chk_val({30'h0, pci_gnt_n}, {30'h0, exp});
    endtask : wait_gnt

    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        // reset values, then reserved bits stuck at zero
        for (int i = 0; i < 4; i++) begin
            rd_chk(addr[i], rst[i]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(addr[i], 8'hff);
            rd_chk(addr[i], msk[i]);
        end
        bus(1'b1, A_WAIT, 8'h00, 4'h0, q);
        rd_chk(A_WAIT, 8'h07);
        wr(10'h1c4, 8'h5a);
        rd_chk(10'h1c4, 8'h00);
        // rows 0-3: two patterns give each row two codes and put every code on two rows
        for (int p = 0; p < 2; p++) begin
            v = p ? 8'h35 : 8'hca;
            wr(A_LOW, v);
            for (int r = 0; r < 4; r++) begin
                dram_chk(3'(r), {v[r+4], v[r]}, {v[r+4], v[r]} != 2'b11);
            end
        end
        // row 4 field and the shared pin functions
        for (int k = 0; k < 4; k++) begin
            wr(A_ROW4, {3'h0, k[1], 3'h0, k[0]});
            rd_chk(A_ROW4, {3'h0, k[1], 3'h0, k[0]});
            chk_val({29'h0, row4_populated, shared_strobe_pin_sel, shared_select_pin_sel},
                    {29'h0, k != 3, k < 2, k == 2});
            dram_chk(3'h4, 2'(k), k != 3);
        end
        dram_chk(3'h5, 2'h0, 1'b0);
        // wait limit per code, the reserved code included
        for (int c = 0; c < 5; c++) begin
            wr(A_WAIT, 8'(c));
            trdy_chk(1'b0, c < 4 ? 2 * c + 2 : 8);
        end
        trdy_chk(1'b1, 1);
        // slice of 12 clocks, the other agent waiting meanwhile
        wr(A_SLC, 8'h0f);
        rd_chk(A_SLC, 8'h0c);
        want <= 2'b01;
        wait_gnt(2'b10);
        want <= 2'b11;
        wait_gnt(2'b01);
        // the model stores the hold length one edge after the grant leaves
        @(posedge core_clk);
        chk_val(32'(last_hold[0]), 32'd13);
        want <= 2'b00;
        // slice off: the owner keeps the bus while it asks
        wr(A_SLC, 8'h00);
        want <= 2'b01;
        wait_gnt(2'b10);
        want <= 2'b11;
        repeat (30) @(posedge core_clk);
        chk_val({30'h0, pci_gnt_n}, 32'h2);
        want <= 2'b10;
        wait_gnt(2'b01);
        @(posedge core_clk);
        chk_val(32'(last_hold[0] > 30), 32'h1);
        wrap_up();
    end
endmodule : dtp_config_top_tb
